// [hdl/seac_top.sv]
// Purpose: Serial EEPROM access control with autoload and AXI4-Lite registers.
// Assumes: Open-drain data line with external pull-up; EEPROM acks each byte.
// Notes:   Control writes are ignored while a cycle or the autoload runs.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Writing one to start bit 0 launches one EEPROM read or write cycle.
// - Command bit: zero reads, one writes; resets to read.
// - Error flag bit 2 sets when an acknowledge is missing in a software cycle, not during autoload; resets to zero.
// - Autoload success bit 3 sets on good autoload, clears when read.
// - Autoload status bit 4 shows one only after a successful autoload.
// - Successful autoload copies EEPROM words into configuration registers.
// - Autoload disable bit 5 suppresses autoload when one; resets to one.
// - Rate field 01b divides the primary clock by 1024; reset value 01b.
// - Rate codes 00b and 10b reserved, 11b selects test mode.
// - Data bits 31:16 supply write data and receive read data.
module seac_top (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	input  wire logic [seac_pkg::AXI_AW-1:0] s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output logic                             s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output logic                             s_axi_wready_o,
	output logic [1:0]                       s_axi_bresp_o,
	output logic                             s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic [seac_pkg::AXI_AW-1:0] s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output logic                             s_axi_arready_o,
	output logic [31:0]                      s_axi_rdata_o,
	output logic [1:0]                       s_axi_rresp_o,
	output logic                             s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	output logic                             irq_o,
	output logic                             eeprom_clk_o,
	input  wire logic                        eeprom_data_i,
	output logic                             eeprom_data_o,
	output logic                             eeprom_data_oe_o,
	output logic [63:0]                      cfg_o
);
	import seac_pkg::*;

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	seac_link_if lnk ();
	seac_state_e     state;
	logic [1:0]      q;
	logic [2:0]      bit_cnt;
	logic [1:0]      byte_idx;
	logic [7:0]      shreg;
	logic [15:0]     rxword;
	logic            eng_rd;
	logic [15:0]     eng_wdata;
	logic            eng_nack;
	logic            ctrl_start;
	logic            ctrl_cmd;
	logic            ctrl_err;
	logic            ctrl_alok;
	logic            ctrl_alst;
	logic            ctrl_aldis;
	logic [1:0]      ctrl_rate;
	logic [6:0]      ctrl_addr;
	logic [15:0]     ctrl_data;
	logic            al_pend;
	logic            al_inflight;
	logic [1:0]      al_idx;
	logic [63:0]     cfg;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic            aw_hold;
	logic            w_hold;
	logic [7:0]      aw_addr;
	logic [31:0]     w_data;
	logic [3:0]      w_strb;
	logic            scl;
	logic            sda_oe;
	logic            next_scl;
	logic            next_sda_oe;
	logic [31:0]     rd_word;
	logic            rd_ok;
	logic            wr_ok;
	logic            eng_idle;
	logic            phase_end;
	logic            sample;
	logic            eng_done;
	logic            sw_launch;
	logic            al_launch;
	logic            launch;
	logic            nack_evt;
	logic            do_write;
	logic            ctrl_wr;
	logic            ctrl_rd;
	logic            busy;
	logic            al_ok_evt;
	logic [IRQ_W-1:0] irq_set;

	seac_divider u_div (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.lnk       (lnk)
	);

	seac_filter u_filt (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.lnk       (lnk)
	);

	assign lnk.rate    = ctrl_rate;
	assign lnk.sda_pin = eeprom_data_i;

	// ****************************************************************
	// Cycle launch and completion.
	// ****************************************************************
	assign eng_idle  = (state == SEAC_IDLE);
	assign phase_end = lnk.qtick && (q == 2'h3);
	assign sample    = lnk.qtick && (q == 2'h2);
	assign eng_done  = phase_end && (state == SEAC_STOP);
	assign sw_launch = ctrl_start && eng_idle && !al_inflight;
	assign al_launch = al_pend && !ctrl_aldis && eng_idle && !ctrl_start && !al_inflight;
	assign launch    = sw_launch || al_launch;
	assign nack_evt  = sample && (state == SEAC_ACKIN) && lnk.sda_level;
	assign busy      = !eng_idle || ctrl_start || al_inflight;
	assign al_ok_evt = eng_done && al_inflight && !eng_nack && (al_idx == 2'(CFG_WORDS - 1));

	// ****************************************************************
	// Serial engine.
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state     <= SEAC_IDLE;
			q         <= 2'h0;
			bit_cnt   <= 3'h0;
			byte_idx  <= 2'h0;
			shreg     <= 8'h00;
			rxword    <= 16'h0000;
			eng_rd    <= 1'b0;
			eng_wdata <= 16'h0000;
			eng_nack  <= 1'b0;
		end else if (launch) begin
			state     <= SEAC_START;
			q         <= 2'h0;
			bit_cnt   <= 3'h0;
			byte_idx  <= 2'h0;
			eng_nack  <= 1'b0;
			eng_rd    <= al_launch || (ctrl_cmd == CMD_READ);
			eng_wdata <= ctrl_data;
			// Address first, direction in the low bit, sent most significant bit first.
			shreg <= al_launch ? {5'h00, al_idx, CMD_READ} : {ctrl_addr, ctrl_cmd};
		end else if (lnk.qtick && !eng_idle) begin
			q <= q + 2'h1;
			if (sample && (state == SEAC_RECV)) begin
				rxword <= {rxword[14:0], lnk.sda_level};
			end
			if (nack_evt) begin
				eng_nack <= 1'b1;
			end
			if (phase_end) begin
				unique case (state)
					SEAC_START: begin
						state <= SEAC_SEND;
					end
					SEAC_SEND: begin
						bit_cnt <= bit_cnt + 3'h1;
						shreg   <= {shreg[6:0], 1'b0};
						if (bit_cnt == 3'h7) begin
							state <= SEAC_ACKIN;
						end
					end
					SEAC_ACKIN: begin
						if (eng_nack || (byte_idx == 2'h2)) begin
							state <= SEAC_STOP;
						end else if (eng_rd) begin
							byte_idx <= 2'h1;
							state    <= SEAC_RECV;
						end else begin
							byte_idx <= byte_idx + 2'h1;
							shreg    <= (byte_idx == 2'h0) ? eng_wdata[15:8] : eng_wdata[7:0];
							state    <= SEAC_SEND;
						end
					end
					SEAC_RECV: begin
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							state <= SEAC_ACKO;
						end
					end
					SEAC_ACKO: begin
						if (byte_idx == 2'h2) begin
							state <= SEAC_STOP;
						end else begin
							byte_idx <= 2'h2;
							state    <= SEAC_RECV;
						end
					end
					SEAC_STOP: begin
						state <= SEAC_IDLE;
					end
					default: begin
						state <= SEAC_IDLE;
					end
				endcase
			end
		end
	end

	// Clock is low for the first half of a bit so the data line only moves then.
	always_comb begin
		next_scl    = 1'b1;
		next_sda_oe = 1'b0;
		unique case (state)
			SEAC_IDLE: begin
				next_scl = 1'b1;
			end
			SEAC_START: begin
				next_sda_oe = q[1];
			end
			SEAC_SEND: begin
				next_scl    = q[1];
				next_sda_oe = !shreg[7];
			end
			SEAC_ACKIN, SEAC_RECV: begin
				next_scl = q[1];
			end
			SEAC_ACKO: begin
				next_scl    = q[1];
				next_sda_oe = (byte_idx == 2'h1);
			end
			SEAC_STOP: begin
				next_scl    = (q != 2'h0);
				next_sda_oe = !q[1];
			end
			default: begin
				next_scl = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			scl    <= 1'b1;
			sda_oe <= 1'b0;
		end else begin
			scl    <= next_scl;
			sda_oe <= next_sda_oe;
		end
	end

	assign eeprom_clk_o     = scl;
	assign eeprom_data_oe_o = sda_oe;
	assign eeprom_data_o    = 1'b0;

	// ****************************************************************
	// Autoload.
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			al_pend     <= 1'b1;
			al_inflight <= 1'b0;
			al_idx      <= 2'h0;
			cfg         <= CFG_DEFAULT;
		end else if (al_launch) begin
			al_inflight <= 1'b1;
		end else if (eng_done && al_inflight) begin
			al_inflight <= 1'b0;
			if (eng_nack) begin
				al_pend <= 1'b0;
			end else begin
				cfg[al_idx*16 +: 16] <= rxword;
				al_idx <= al_idx + 2'h1;
				if (al_idx == 2'(CFG_WORDS - 1)) begin
					al_pend <= 1'b0;
				end
			end
		end
	end

	assign cfg_o = cfg;

	// ****************************************************************
	// AXI4-Lite slave.
	// ****************************************************************
	assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_hold && !s_axi_bvalid_o;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign do_write        = aw_hold && w_hold && !s_axi_bvalid_o;
	assign ctrl_wr         = do_write && (aw_addr == ADDR_CTRL);
	assign ctrl_rd         = s_axi_arvalid_i && s_axi_arready_o && (s_axi_araddr_i == ADDR_CTRL);
	assign wr_ok           = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_IRQ_CLR)
	                      || (aw_addr == ADDR_IRQ_EN);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			aw_hold        <= 1'b0;
			w_hold         <= 1'b0;
			aw_addr        <= 8'h00;
			w_data         <= 32'h0000_0000;
			w_strb         <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (do_write) begin
				aw_hold        <= 1'b0;
				w_hold         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (s_axi_araddr_i == ADDR_CTRL) begin
			rd_word = {ctrl_data, ctrl_addr, 1'b0, ctrl_rate, ctrl_aldis, ctrl_alst,
			           ctrl_alok, ctrl_err, ctrl_cmd, ctrl_start};
		end else if (s_axi_araddr_i == ADDR_IRQ_STAT) begin
			rd_word = {29'h0000_0000, irq_stat};
		end else if (s_axi_araddr_i == ADDR_IRQ_EN) begin
			rd_word = {29'h0000_0000, irq_en};
		end else if (s_axi_araddr_i == ADDR_IRQ_CLR) begin
			rd_word = 32'h0000_0000;
		end else if ((s_axi_araddr_i >= ADDR_CFG0) && (s_axi_araddr_i[1:0] == 2'h0)
		             && (s_axi_araddr_i < ADDR_CFG0 + 8'(4 * CFG_WORDS))) begin
			rd_word = {16'h0000, cfg[s_axi_araddr_i[3:2]*16 +: 16]};
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= rd_word;
			s_axi_rresp_o  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ****************************************************************
	// Control register.
	// ****************************************************************
	// Writes during a cycle are dropped so the engine never sees its operands move.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_start <= 1'b0;
			ctrl_cmd   <= CMD_READ;
			ctrl_aldis <= ALDIS_RST;
			ctrl_rate  <= RATE_RST;
			ctrl_addr  <= 7'h00;
			ctrl_data  <= 16'h0000;
		end else if (eng_done && !al_inflight) begin
			ctrl_start <= 1'b0;
			if (eng_rd && !eng_nack) begin
				ctrl_data <= rxword;
			end
		end else if (ctrl_wr && !busy) begin
			if (w_strb[0]) begin
				ctrl_start <= w_data[BIT_START];
				ctrl_cmd   <= w_data[BIT_CMD];
				ctrl_aldis <= w_data[BIT_ALDIS];
				ctrl_rate  <= w_data[RATE_LSB +: 2];
			end
			if (w_strb[1]) begin
				ctrl_addr <= w_data[ADDR_LSB +: 7];
			end
			if (w_strb[2]) begin
				ctrl_data[7:0] <= w_data[DATA_LSB +: 8];
			end
			if (w_strb[3]) begin
				ctrl_data[15:8] <= w_data[DATA_LSB+8 +: 8];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_err  <= 1'b0;
			ctrl_alok <= 1'b0;
			ctrl_alst <= 1'b0;
		end else begin
			if (sw_launch) begin
				ctrl_err <= 1'b0;
			end else if (nack_evt && !al_inflight) begin
				ctrl_err <= 1'b1;
			end
			if (al_ok_evt) begin
				ctrl_alok <= 1'b1;
				ctrl_alst <= 1'b1;
			end else if (ctrl_rd) begin
				ctrl_alok <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Interrupts.
	// ****************************************************************
	assign irq_set = {eng_done && al_inflight && (eng_nack || al_ok_evt), nack_evt,
	                  eng_done && !al_inflight};

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_stat <= '0;
			irq_en   <= '0;
		end else begin
			// A new event in the clearing cycle keeps its bit.
			irq_stat <= (irq_stat & ~((do_write && aw_addr == ADDR_IRQ_CLR && w_strb[0])
			             ? w_data[IRQ_W-1:0] : '0)) | irq_set;
			if (do_write && (aw_addr == ADDR_IRQ_EN) && w_strb[0]) begin
				irq_en <= w_data[IRQ_W-1:0];
			end
		end
	end

	assign irq_o = |(irq_stat & irq_en);

	// ****************************************************************
	// Checks.
	// ****************************************************************
	sequence s_nack;
		nack_evt && !al_inflight;
	endsequence

	sequence s_sw_read_ok;
		eng_done && !al_inflight && eng_rd && !eng_nack;
	endsequence

	property p_start_clears;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		eng_done && !al_inflight |=> !ctrl_start && eng_idle;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start bit not cleared");

	property p_nack_flag;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_nack |=> ctrl_err ##1 irq_stat[IRQ_NACK];
	endproperty
	a_nack_flag: assert property (p_nack_flag) else $error("missing ack not flagged");

	property p_nack_abort;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		nack_evt |-> ##[1:300] (state == SEAC_STOP);
	endproperty
	a_nack_abort: assert property (p_nack_abort) else $error("nack did not abort");

	property p_read_data;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_sw_read_ok |=> ctrl_data == $past(rxword);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data not loaded");

	property p_alok_read_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		ctrl_rd && !al_ok_evt |=> !ctrl_alok;
	endproperty
	a_alok_read_clear: assert property (p_alok_read_clear) else $error("bit 3 kept");

	property p_al_status;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		al_ok_evt |=> ctrl_alst && ctrl_alok && (cfg[63:48] == $past(rxword));
	endproperty
	a_al_status: assert property (p_al_status) else $error("autoload result lost");

	property p_al_disabled;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(al_inflight) |-> !$past(ctrl_aldis);
	endproperty
	a_al_disabled: assert property (p_al_disabled) else $error("autoload ran disabled");

	property p_rate_normal;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		lnk.qtick && (ctrl_rate == RATE_NORMAL) |=> (!lnk.qtick || (ctrl_rate == RATE_TEST)) [*8];
	endproperty
	a_rate_normal: assert property (p_rate_normal) else $error("divider too fast");

	property p_rate_test;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		lnk.qtick && (ctrl_rate == RATE_TEST) |=> !lnk.qtick ##1 (lnk.qtick || (ctrl_rate != RATE_TEST));
	endproperty
	a_rate_test: assert property (p_rate_test) else $error("test rate not applied");

	property p_launch;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		sw_launch |=> (state == SEAC_START) && ctrl_start [*2];
	endproperty
	a_launch: assert property (p_launch) else $error("start did not launch");
endmodule
`default_nettype wire

// [hdl/seac_pkg.sv]
// Purpose: Shared constants and types of the serial EEPROM access block.
// Assumes: 32-bit AXI4-Lite register bus with byte addresses.
// Notes:   Every offset, field position, reset value and count lives here.
package seac_pkg;
	// ****************************************************************
	// Register map.
	// ****************************************************************
	localparam int             AXI_AW        = 8;
	localparam logic [7:0]     ADDR_CTRL     = 8'hBC;
	localparam logic [7:0]     ADDR_IRQ_STAT = 8'hC0;
	localparam logic [7:0]     ADDR_IRQ_CLR  = 8'hC4;
	localparam logic [7:0]     ADDR_IRQ_EN   = 8'hC8;
	localparam logic [7:0]     ADDR_CFG0     = 8'hD0;
	localparam logic [1:0]     RESP_OKAY     = 2'h0;
	localparam logic [1:0]     RESP_SLVERR   = 2'h2;

	// ****************************************************************
	// Control register fields.
	// ****************************************************************
	localparam int             BIT_START     = 0;
	localparam int             BIT_CMD       = 1;
	localparam int             BIT_ERR       = 2;
	localparam int             BIT_ALOK      = 3;
	localparam int             BIT_ALST      = 4;
	localparam int             BIT_ALDIS     = 5;
	localparam int             RATE_LSB      = 6;
	localparam int             ADDR_LSB      = 9;
	localparam int             DATA_LSB      = 16;
	localparam logic           CMD_READ      = 1'b0;
	localparam logic           CMD_WRITE     = 1'b1;
	localparam logic           ALDIS_RST     = 1'b1;
	localparam logic [1:0]     RATE_NORMAL   = 2'h1;
	localparam logic [1:0]     RATE_TEST     = 2'h3;
	localparam logic [1:0]     RATE_RST      = 2'h1;

	// ****************************************************************
	// Interrupt status bits.
	// ****************************************************************
	localparam int             IRQ_W         = 3;
	localparam int             IRQ_DONE      = 0;
	localparam int             IRQ_NACK      = 1;
	localparam int             IRQ_AL        = 2;

	// ****************************************************************
	// Link timing: four quarter ticks make one EEPROM clock period.
	// ****************************************************************
	localparam int             DIV_NORMAL    = 1024;
	localparam int             QUARTERS      = 4;
	localparam logic [7:0]     QUARTER_LAST  = 8'(DIV_NORMAL / QUARTERS - 1);

	// ****************************************************************
	// Autoload image.
	// ****************************************************************
	localparam int             CFG_WORDS     = 4;
	localparam logic [63:0]    CFG_DEFAULT   = 64'h0000_0000_0000_0000;

	typedef enum logic [2:0] {
		SEAC_IDLE  = 3'b000,
		SEAC_START = 3'b001,
		SEAC_SEND  = 3'b010,
		SEAC_ACKIN = 3'b011,
		SEAC_RECV  = 3'b100,
		SEAC_ACKO  = 3'b101,
		SEAC_STOP  = 3'b110
	} seac_state_e;
endpackage

// [hdl/seac_link_if.sv]
// Purpose: Carries the bit timing and the cleaned data line between modules.
// Assumes: One clock domain.
// Notes:   The core picks the rate, the divider ticks, the filter cleans.
`timescale 1ns/1ps
`default_nettype none
interface seac_link_if;
	logic [1:0] rate;
	logic       qtick;
	logic       sda_pin;
	logic       sda_level;
	modport core (output rate, output sda_pin, input qtick, input sda_level);
	modport div  (input rate, output qtick);
	modport filt (input sda_pin, output sda_level);
endinterface
`default_nettype wire

// [hdl/seac_divider.sv]
// Purpose: Quarter-period tick generator for the EEPROM clock.
// Assumes: clk_sys_i stands as the primary clock.
// Notes:   Reserved rate codes run at the normal rate.
`timescale 1ns/1ps
`default_nettype none
module seac_divider (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	seac_link_if.div  lnk
);
	import seac_pkg::*;
	logic [7:0] cnt;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cnt <= 8'h00;
		end else if (cnt == QUARTER_LAST) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	// Test mode ticks every other cycle, so the link runs at an eighth of the clock.
	// A tick on every cycle would sample the data pin before the three-stage filter
	// has passed the new level through, and every received bit would be stale.
	assign lnk.qtick = (lnk.rate == RATE_TEST) ? cnt[0] : (cnt == QUARTER_LAST);
endmodule
`default_nettype wire

// [hdl/seac_filter.sv]
// Purpose: Three-stage synchroniser for the EEPROM data pin.
// Assumes: The pin is asynchronous to clk_sys_i.
// Notes:   The level moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module seac_filter (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	seac_link_if.filt lnk
);
	logic s1;
	logic s2;
	logic s3;
	logic level;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s1    <= 1'b1;
			s2    <= 1'b1;
			s3    <= 1'b1;
			level <= 1'b1;
		end else begin
			s1 <= lnk.sda_pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end

	assign lnk.sda_level = level;
endmodule
`default_nettype wire

// [testbench/seac_eeprom_model.sv]
// Purpose: Behavioural serial EEPROM on the far side of the link.
// Assumes: Open-drain data line with a pull-up outside this model.
// Notes:   Word k holds {k, k xor C3} so every location is distinct.
`timescale 1ns/1ps
`default_nettype none
module seac_eeprom_model (
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic nack_i,
	output logic      pull_low_o
);
	logic [15:0] mem [0:127];
	logic [7:0]  sh, cmd, hi;
	int          cnt, nb;
	initial begin
		pull_low_o = 1'b0;
		cnt = 0;
		nb = 0;
		for (int i = 0; i < 128; i++) mem[i] = {8'(i), 8'(8'hC3 ^ i)};
	end
	always @(negedge sda_i) if (scl_i) begin
		cnt = 0;
		nb = 0;
	end
	// Bits are taken on the rising clock; the ninth bit of a byte is the acknowledge.
	always @(posedge scl_i) begin
		if (cnt < 8) begin
			sh = {sh[6:0], sda_i};
			cnt++;
		end else begin
			cnt = 0;
			if (nb == 0) cmd = sh;
			if (nb == 1) hi = sh;
			if (nb == 2 && cmd[0]) mem[cmd[7:1]] = {hi, sh};
			nb++;
		end
	end
	// Changes its drive only at the falling clock; a refused cycle gets no read data.
	always @(negedge scl_i) begin
		if (cnt == 8) pull_low_o <= (nb == 0 || cmd[0]) && !nack_i;
		else if (nb > 0 && nb < 3 && !cmd[0] && !nack_i)
			pull_low_o <= !mem[cmd[7:1]][(nb == 1 ? 15 : 7) - cnt];
		else pull_low_o <= 1'b0;
	end
endmodule
`default_nettype wire

// [testbench/seac_top_tb.sv]
// Purpose: Self-checking bench for the serial EEPROM access block.
// Assumes: Test rate for long transfers, normal rate for one short cycle.
// Notes:   Handshakes are sampled at the falling edge, acted on at the rising.
`timescale 1ns/1ps
`default_nettype none
module seac_top_tb;
	import seac_pkg::*;
	logic        clk, rst_n, awv, wv, bv, brdy, arv, rv, rrdy, irq, eclk, doe, low, nack;
	logic        awr, wr_r, arr, dq;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat;
	logic [1:0]  br, rr, wresp;
	logic [63:0] cfg;
	int          bad_count, checked;
	wire         sda = (doe || low) ? 1'b0 : 1'b1;
	seac_top dut (.clk_sys_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rrdy), .irq_o(irq), .eeprom_clk_o(eclk), .eeprom_data_i(sda),
		.eeprom_data_o(dq), .eeprom_data_oe_o(doe), .cfg_o(cfg));
	seac_eeprom_model m (.scl_i(eclk), .sda_i(sda), .nack_i(nack), .pull_low_o(low));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic tmo;
		bad_count++;
		finish_test();
	endtask
	task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge clk);
		{awa, wd, awv, wv, brdy} <= {a, d, 3'b111};
		for (int n = 0; n < 50 && !tb; n++) begin
			@(negedge clk);
			{ta, tw, tb, wresp} = {awv && awr, wv && wr_r, bv, br};
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		brdy <= 1'b0;
		if (!tb) tmo();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		tr = 1'b0;
		@(posedge clk);
		{ara, arv, rrdy} <= {a, 2'b11};
		for (int n = 0; n < 50 && !tr; n++) begin
			@(negedge clk);
			{ta, tr, d, r} = {arv && arr, rv, rdat, rr};
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end
		rrdy <= 1'b0;
		if (!tr) tmo();
	endtask
	task automatic poll(input logic [7:0] a, input int b, input logic w, output logic [31:0] v);
		logic [1:0] r;
		for (int n = 0; n < 9000; n++) begin
			rd(a, v, r);
			if (v[b] === w) return;
		end
		tmo();
	endtask
	task automatic t_reset;
		logic [31:0] v;
		logic [1:0]  r;
		rd(ADDR_CTRL, v, r);
		chk("ctrl reset", 32'h0000_0060, v);
		rd(8'h00, v, r);
		chk("unmapped resp", RESP_SLVERR, r);
		chk("data out level", 1'b0, dq);
		wr(8'h00, 32'h0000_0001);
		chk("unmapped write resp", RESP_SLVERR, wresp);
	endtask
	task automatic t_autoload;
		logic [31:0] v;
		logic [63:0] e;
		logic [1:0]  r;
		for (int k = 0; k < 4; k++) e[16*k+:16] = {8'(k), 8'(8'hC3 ^ k)};
		wr(ADDR_CTRL, 32'h0000_00C0);
		poll(ADDR_IRQ_STAT, IRQ_AL, 1'b1, v);
		chk("cfg image", e, cfg);
		chk("masked irq", 1'b0, irq);
		rd(ADDR_CTRL, v, r);
		chk("autoload ok bits", 2'b11, v[4:3]);
		rd(ADDR_CTRL, v, r);
		chk("ok bit after read", 1'b0, v[3]);
	endtask
	task automatic t_cycles;
		logic [31:0] v;
		wr(ADDR_IRQ_EN, 32'h1);
		chk("write resp", RESP_OKAY, wresp);
		wr(ADDR_CTRL, {16'h5AA5, 7'h2A, 9'h0E3});
		poll(ADDR_CTRL, BIT_START, 1'b0, v);
		chk("written word", 16'h5AA5, m.mem[7'h2A]);
		chk("irq done", 1'b1, irq);
		wr(ADDR_IRQ_CLR, 32'h1);
		chk("irq cleared", 1'b0, irq);
		wr(ADDR_CTRL, {16'h0, 7'h11, 9'h0E1});
		poll(ADDR_CTRL, BIT_START, 1'b0, v);
		chk("read word", 16'h11D2, v[31:16]);
	endtask
	task automatic t_nack;
		logic [31:0] v;
		logic        p;
		int          n, k;
		p = 1'b1;
		k = 0;
		nack <= 1'b1;
		wr(ADDR_CTRL, {16'h0, 7'h05, 9'h061});
		for (int i = 0; i < 9000 && k < 3; i++) begin
			@(negedge clk);
			n++;
			if (eclk && !p) begin
				k++;
				if (k == 2) n = 0;
			end
			p = eclk;
		end
		chk("clock period", DIV_NORMAL, n);
		poll(ADDR_CTRL, BIT_START, 1'b0, v);
		chk("error flag", 1'b1, v[BIT_ERR]);
	endtask
	initial begin
		{rst_n, awv, wv, brdy, arv, rrdy, nack, awa, ara, wd} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_autoload();
		t_cycles();
		t_nack();
		finish_test();
	end
endmodule
`default_nettype wire
